// >>> scp_pkg.sv
// Purpose: constants and types for the system clock select and prescaler block
// Assumes: 100 MHz master clock, classic Wishbone register access
// Notes:   register byte address is four times the register index
//
// Summary of operation
// - rc source: 6 CK wake, selectable reset delay
// - reset-disable fuse stretches shortest delay to 4.1ms
// - watchdog keeps its own oscillator clock
// - source code 0011 selects 128kHz oscillator
// - 128kHz source: 6 CK wake, 4ms/64ms delays
// - source code 0000 selects external clock pin
// - external source: 6 CK wake, selectable delays
// - clock output fuse drives clock pin, even in reset
// - clock pin carries the divided system clock, the undivided source clock in reset
// - timer oscillator allowed only with rc source
// - timer external clock enable accepts pin-one clock
// - prescaler divides cpu, io and flash alike
// - division change glitch-free, no faster intermediate
// - new division active within T1 to T1+2T2
// - counter state not readable by software
// - change enable opens only with zero others
// - select codes 0..8 give divide 1..256
// - reset select 0011 with fuse, else 0000
`default_nettype none
package scp_pkg;
    // ==========================================================
    // register map (index, byte address is index times four)
    localparam logic [7:0]  PRESCALE_IDX    = 8'h61;
    localparam logic [7:0]  TIMER_CTRL_IDX  = 8'h70;
    localparam logic [7:0]  STATUS_IDX      = 8'h71;
    localparam int          PCE_BIT         = 7;
    localparam int          EXT_CLK_BIT     = 0;
    localparam logic [3:0]  SEL_RESET_DIV8  = 4'h3;
    localparam logic [3:0]  SEL_RESET_PLAIN = 4'h0;
    localparam logic [3:0]  SEL_MAX         = 4'h8;
    localparam logic [2:0]  PCE_WINDOW      = 3'h4;
    // ==========================================================
    // clock source and start-up codes
    localparam logic [3:0]  SRC_EXT         = 4'h0;
    localparam logic [3:0]  SRC_RC          = 4'h2;
    localparam logic [3:0]  SRC_LF          = 4'h3;
    localparam logic [1:0]  STARTUP_SHORT   = 2'h0;
    localparam logic [1:0]  STARTUP_MID     = 2'h1;
    // ==========================================================
    // timing
    localparam int          CLK_MHZ         = 100;
    localparam int          BASE_CK         = 19;
    localparam int          WAKE_CK         = 6;
    localparam int          T_4P1MS_US      = 4100;
    localparam int          T_65MS_US       = 65000;
    localparam int          T_4MS_US        = 4000;
    localparam int          T_64MS_US       = 64000;
    // ==========================================================
    // static configuration carrier
    typedef struct packed {
        logic [3:0] clock_source_select;
        logic [1:0] startup_time_select;
        logic       reset_pin_disable_fuse;
        logic       clock_output_fuse;
        logic       divide_by_eight_fuse;
    } scp_cfg_t;
    typedef struct packed {
        logic [11:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } scp_wb_req_t;
endpackage
`default_nettype wire

// >>> scp_top.sv
// Purpose: clock source selection, start-up delay and glitch-free system prescaler
// Assumes: oscillator and pin inputs are synchronous to clk_i, clk_i is the undivided master
// Notes:   the divided clock is delivered as a one-cycle enable, the pin as a toggle
`timescale 1ns/10ps
`default_nettype none
module scp_top #(
    parameter int DLY_4P1MS_CYC = scp_pkg::T_4P1MS_US * scp_pkg::CLK_MHZ,
    parameter int DLY_65MS_CYC  = scp_pkg::T_65MS_US * scp_pkg::CLK_MHZ,
    parameter int DLY_4MS_CYC   = scp_pkg::T_4MS_US * scp_pkg::CLK_MHZ,
    parameter int DLY_64MS_CYC  = scp_pkg::T_64MS_US * scp_pkg::CLK_MHZ
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // static configuration
    input  wire scp_pkg::scp_cfg_t    cfg_i,
    // oscillators and pins
    input  wire logic                 rc_osc_i,
    input  wire logic                 lf_osc_i,
    input  wire logic                 wdt_osc_i,
    input  wire logic                 external_clock_pin_i,
    input  wire logic                 timer_osc_pin_one_i,
    input  wire logic                 wake_i,
    // wishbone slave
    input  wire scp_pkg::scp_wb_req_t wb_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    // clocks out
    output logic                      sys_src_clk_o,
    output logic                      sys_clk_en_o,
    output logic                      wdt_clk_o,
    output logic                      clock_output_pin_o,
    output logic                      clock_output_oe_n_o,
    output logic                      timer_clk_o,
    output logic                      timer_osc_allowed_o,
    output logic                      cpu_run_o
);
    // ==========================================================
    // helpers
    function automatic logic [7:0] div_last(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > scp_pkg::SEL_MAX) ? scp_pkg::SEL_MAX : sel;
        div_last = 8'((9'h001 << s) - 9'h001);
    endfunction

    function automatic logic [31:0] extra_dly(input scp_pkg::scp_cfg_t c);
        logic lf;
        lf = (c.clock_source_select == scp_pkg::SRC_LF);
        extra_dly = 32'h0;
        if (c.startup_time_select == scp_pkg::STARTUP_SHORT)
        begin
            if (c.reset_pin_disable_fuse)
                extra_dly = 32'(DLY_4P1MS_CYC);
        end
        else if (c.startup_time_select == scp_pkg::STARTUP_MID)
            extra_dly = lf ? 32'(DLY_4MS_CYC) : 32'(DLY_4P1MS_CYC);
        else
            extra_dly = lf ? 32'(DLY_64MS_CYC) : 32'(DLY_65MS_CYC);
    endfunction

    // ==========================================================
    // static configuration capture
    scp_pkg::scp_cfg_t cfg_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cfg_q <= cfg_i;
    end

    // ==========================================================
    // source selection
    logic [3:0] src_sel;
    logic       src_lvl;
    logic       src_clk_q;
    logic       rc_sel;
    assign src_sel = rst_i ? cfg_i.clock_source_select : cfg_q.clock_source_select;
    assign rc_sel  = (cfg_q.clock_source_select == scp_pkg::SRC_RC);
    always_comb
    begin
        case (src_sel)
            scp_pkg::SRC_EXT: src_lvl = external_clock_pin_i;
            scp_pkg::SRC_LF:  src_lvl = lf_osc_i;
            default:          src_lvl = rc_osc_i;
        endcase
    end
    always_ff @(posedge clk_i)
    begin
        src_clk_q <= src_lvl;
        wdt_clk_o <= wdt_osc_i;
    end
    assign sys_src_clk_o = src_clk_q;

    // ==========================================================
    // wishbone slave
    logic        req;
    logic        hit_pre;
    logic        hit_tmr;
    logic        hit_sta;
    logic        wr_pre;
    logic [7:0]  wbyte;
    assign req     = wb_i.cyc && wb_i.stb && !wb_ack_o;
    assign hit_pre = (wb_i.adr[11:2] == {2'h0, scp_pkg::PRESCALE_IDX});
    assign hit_tmr = (wb_i.adr[11:2] == {2'h0, scp_pkg::TIMER_CTRL_IDX});
    assign hit_sta = (wb_i.adr[11:2] == {2'h0, scp_pkg::STATUS_IDX});
    assign wbyte   = wb_i.dat[7:0];
    assign wr_pre  = req && wb_i.we && wb_i.sel[0] && hit_pre;

    // ==========================================================
    // prescale control register
    logic [3:0] sel_q;
    logic       pce_q;
    logic [2:0] pce_cnt_q;
    logic       tick_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_q     <= cfg_i.divide_by_eight_fuse ? scp_pkg::SEL_RESET_DIV8 : scp_pkg::SEL_RESET_PLAIN;
            pce_q     <= 1'b0;
            pce_cnt_q <= 3'h0;
        end
        else
        begin
            if (wr_pre && !wbyte[scp_pkg::PCE_BIT] && pce_q)
            begin
                sel_q  <= wbyte[3:0];
                pce_q  <= 1'b0;
            end
            else if (wr_pre && wbyte == 8'h80 && !pce_q)
            begin
                pce_q     <= 1'b1;
                pce_cnt_q <= scp_pkg::PCE_WINDOW;
            end
            else if (pce_q && tick_q)
            begin
                pce_cnt_q <= pce_cnt_q - 3'h1;
                if (pce_cnt_q == 3'h1)
                    pce_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // timer oscillator control
    logic ext_en_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ext_en_q <= 1'b0;
        else if (req && wb_i.we && wb_i.sel[0] && hit_tmr)
            ext_en_q <= wbyte[scp_pkg::EXT_CLK_BIT];
    end
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_osc_allowed_o <= 1'b0;
            timer_clk_o         <= 1'b0;
        end
        else
        begin
            timer_osc_allowed_o <= rc_sel;
            timer_clk_o         <= rc_sel && ext_en_q && timer_osc_pin_one_i;
        end
    end

    // ==========================================================
    // synchronous counter prescaler, updated only at a period boundary
    logic [3:0] act_q;
    logic [7:0] cnt_q;
    logic       wrap;
    assign wrap = (cnt_q >= div_last(act_q));
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            act_q  <= cfg_i.divide_by_eight_fuse ? scp_pkg::SEL_RESET_DIV8 : scp_pkg::SEL_RESET_PLAIN;
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= wrap;
            if (wrap)
            begin
                cnt_q <= 8'h00;
                act_q <= sel_q;
            end
            else
                cnt_q <= cnt_q + 8'h01;
        end
    end
    assign sys_clk_en_o = tick_q;

    // ==========================================================
    // clock output pin
    logic div_tog_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_tog_q           <= 1'b0;
            clock_output_pin_o  <= cfg_i.clock_output_fuse && src_clk_q;
            clock_output_oe_n_o <= !cfg_i.clock_output_fuse;
        end
        else
        begin
            if (tick_q)
                div_tog_q <= !div_tog_q;
            clock_output_pin_o  <= cfg_q.clock_output_fuse && div_tog_q;
            clock_output_oe_n_o <= !cfg_q.clock_output_fuse;
        end
    end

    // ==========================================================
    // start-up delay after reset and wake
    logic [31:0] dly_q;
    logic        boot_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dly_q     <= 32'h0;
            boot_q    <= 1'b1;
            cpu_run_o <= 1'b0;
        end
        else if (boot_q)
        begin
            boot_q <= 1'b0;
            dly_q  <= 32'(scp_pkg::BASE_CK - 1) + extra_dly(cfg_q);
        end
        else if (wake_i)
        begin
            dly_q     <= 32'(scp_pkg::WAKE_CK - 1);
            cpu_run_o <= 1'b0;
        end
        else if (dly_q != 32'h0)
            dly_q <= dly_q - 32'h1;
        else
            cpu_run_o <= 1'b1;
    end

    // ==========================================================
    // read data and acknowledge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h0;
            if (req && !wb_i.we)
            begin
                if (hit_pre)
                    wb_dat_o <= {24'h0, pce_q, 3'h0, sel_q};
                else if (hit_tmr)
                    wb_dat_o <= {31'h0, ext_en_q};
                else if (hit_sta)
                    wb_dat_o <= {24'h0, timer_osc_allowed_o, cpu_run_o, 2'h0, cfg_q.clock_source_select};
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence unlock_s;
        wr_pre && wbyte == 8'h80 && !pce_q;
    endsequence
    sequence set_s;
        wr_pre && !wbyte[scp_pkg::PCE_BIT] && pce_q;
    endsequence

    pce_open_a: assert property (unlock_s |=> pce_q && pce_cnt_q == scp_pkg::PCE_WINDOW)
        else $error("change enable did not open");
    pce_close_a: assert property (set_s |=> !pce_q && sel_q == $past(wbyte[3:0]))
        else $error("division write not taken");
    pce_gate_a: assert property (wr_pre && !pce_q && !wbyte[scp_pkg::PCE_BIT] |=> $stable(sel_q))
        else $error("select changed without unlock");
    div_bound_a: assert property (set_s |-> ##[1:257] (act_q == sel_q))
        else $error("new division not active in time");
    div_edge_a: assert property ($changed(act_q) |-> $past(wrap))
        else $error("division changed mid period");
    tick_gap_a: assert property (tick_q && act_q == 4'h1 && $past(act_q) == 4'h1 |=> !tick_q ##1 tick_q)
        else $error("divide by two period wrong");
    tmr_gate_a: assert property (!rc_sel |=> !timer_osc_allowed_o && !timer_clk_o)
        else $error("timer oscillator outside rc mode");
    clock_output_fuse_a: assert property (!cfg_q.clock_output_fuse |=> !clock_output_pin_o && clock_output_oe_n_o)
        else $error("clock pin driven without fuse");
    wake_a: assert property (wake_i && !boot_q |=> !cpu_run_o [*6] ##1 (cpu_run_o || wake_i))
        else $error("wake delay not six cycles");
    ack_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");
    clock_output_fuse_tog_a: assert property (cfg_q.clock_output_fuse && tick_q |=> ##1 $changed(clock_output_pin_o))
        else $error("clock pin did not follow divided clock");
endmodule
`default_nettype wire

// >>> scp_osc_model.sv
// Purpose: oscillator and pin levels feeding scp_top
// Assumes: levels change just after clk_i rises
// Notes:   half periods in clk_i cycles
`timescale 1ns/10ps
`default_nettype none
module scp_osc_model #(
    parameter int RC_HALF   = 1,
    parameter int LF_HALF   = 5,
    parameter int WDT_HALF  = 7,
    parameter int EXT_HALF  = 2,
    parameter int TOSC_HALF = 17
) (
    // clock
    input  wire logic clk_i,
    // levels
    output logic      rc_osc_o,
    output logic      lf_osc_o,
    output logic      wdt_osc_o,
    output logic      ext_clk_o,
    output logic      tosc_one_o
);
    int cnt_q = 0;
    // ==========================================================
    // free running count
    always_ff @(posedge clk_i)
    begin
        cnt_q <= cnt_q + 1;
    end
    // ==========================================================
    // levels
    assign rc_osc_o   = 1'((cnt_q / RC_HALF) % 2);
    assign lf_osc_o   = 1'((cnt_q / LF_HALF) % 2);
    assign wdt_osc_o  = 1'((cnt_q / WDT_HALF) % 2);
    assign ext_clk_o  = 1'((cnt_q / EXT_HALF) % 2);
    assign tosc_one_o = 1'((cnt_q / TOSC_HALF) % 2);
endmodule
`default_nettype wire

// >>> scp_top_tb.sv
// Purpose: self-checking bench for scp_top
// Assumes: ack one cycle after a request
// Notes:   shortened start-up delays
`timescale 1ns/10ps
`default_nettype none
module scp_top_tb;
    typedef struct {
        scp_pkg::scp_cfg_t c;
        int                dly;
        logic              alw;
    } scp_row_t;
    localparam logic [11:0] A_PS = {2'h0, scp_pkg::PRESCALE_IDX, 2'h0};
    localparam logic [11:0] A_TC = {2'h0, scp_pkg::TIMER_CTRL_IDX, 2'h0};
    localparam logic [11:0] A_ST = {2'h0, scp_pkg::STATUS_IDX, 2'h0};
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 wake  = 1'b0;
    scp_pkg::scp_cfg_t    cfg   = '0;
    scp_pkg::scp_wb_req_t wb    = '0;
    logic [31:0]          rd;
    logic                 ack, en, run, alw, pin, oe_n, tclk, wclk, sclk;
    logic                 rc, lf, wdt, ext, t1;
    logic [31:0]          q;
    logic [3:0]           codes[4] = '{4'h1, 4'h4, 4'h0, 4'h8};
    int                   errors = 0;
    int                   num_checks = 0;
    int                   i, k, n, prev;
    scp_row_t rows[9] = '{
        '{{4'h2, 2'h1, 3'b001}, 40, 1'b1}, '{{4'h2, 2'h2, 3'b010}, 65, 1'b1},
        '{{4'h2, 2'h0, 3'b100}, 40, 1'b1}, '{{4'h3, 2'h1, 3'b010}, 30, 1'b0},
        '{{4'h3, 2'h2, 3'b001}, 60, 1'b0}, '{{4'h3, 2'h0, 3'b100}, 40, 1'b0},
        '{{4'h0, 2'h0, 3'b010}, 0, 1'b0}, '{{4'h0, 2'h1, 3'b000}, 40, 1'b0},
        '{{4'h2, 2'h0, 3'b010}, 0, 1'b1}};
    always #5 clk_i = ~clk_i;
    // ==========================================================
    // design and far side
    scp_top #(.DLY_4P1MS_CYC(40), .DLY_65MS_CYC(65), .DLY_4MS_CYC(30), .DLY_64MS_CYC(60)) u_scp_top (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .rc_osc_i(rc), .lf_osc_i(lf), .wdt_osc_i(wdt),
        .external_clock_pin_i(ext), .timer_osc_pin_one_i(t1), .wake_i(wake), .wb_i(wb),
        .wb_dat_o(rd), .wb_ack_o(ack), .sys_src_clk_o(sclk), .sys_clk_en_o(en), .wdt_clk_o(wclk),
        .clock_output_pin_o(pin), .clock_output_oe_n_o(oe_n), .timer_clk_o(tclk),
        .timer_osc_allowed_o(alw), .cpu_run_o(run));
    scp_osc_model u_scp_osc_model (.clk_i(clk_i), .rc_osc_o(rc), .lf_osc_o(lf), .wdt_osc_o(wdt),
        .ext_clk_o(ext), .tosc_one_o(t1));
    // ==========================================================
    // tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rng(input string s, input int lo, input int hi, input int g);
        num_checks++;
        if (g < lo || g > hi)
        begin
            errors++;
            $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
        int j;
        wb <= '{adr: a, dat: {24'h0, d}, sel: 4'h1, we: w, cyc: 1'b1, stb: 1'b1};
        for (j = 0; j < 20 && ack !== 1'b1; j++) @(posedge clk_i);
        r = rd;
        wb <= '0;
        if (j == 20)
        begin
            errors++;
            end_sim();
        end
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(a, 1'b1, d, x);
    endtask
    task automatic follow(input logic [3:0] s, input logic al);
        logic a, b, c;
        @(negedge clk_i);
        repeat (40)
        begin
            a = (s == scp_pkg::SRC_EXT) ? ext : (s == scp_pkg::SRC_LF) ? lf : rc;
            b = wdt;
            c = al & t1;
            @(negedge clk_i);
            chk("src_clk", 32'(a), 32'(sclk));
            chk("wdt_clk", 32'(b), 32'(wclk));
            chk("timer_clk", 32'(c), 32'(tclk));
        end
        @(posedge clk_i);
    endtask
    task automatic meas(input int p1, input int p2);
        int j, f, l, g, gm, pk, pg;
        logic pp;
        f = -1; l = 0; g = 0; gm = 1000; pk = 0; pg = 0; pp = pin;
        for (j = 0; j < 4 * p2 + 2 * p1; j++)
        begin
            @(posedge clk_i);
            if (en === 1'b1)
            begin
                g = j - l;
                if (f >= 0 && g < gm) gm = g;
                if (f < 0) f = j;
                l = j;
            end
            if (pin !== pp)
            begin
                pg = j - pk;
                pk = j;
            end
            pp = pin;
        end
        rng("first_edge", 0, p1 + 2 * p2, f);
        rng("min_gap", (p1 < p2) ? p1 : p2, 1000, gm);
        rng("gap", p2, p2, g);
        rng("pin_half", p2, p2, pg);
    endtask
    // ==========================================================
    // sequence
    initial
    begin
        for (i = 0; i < 9; i++)
        begin
            cfg <= rows[i].c;
            rst_i <= 1'b1;
            n = 0;
            for (k = 0; k < 16; k++)
            begin
                @(posedge clk_i);
                if (k > 4 && pin !== q[0]) n++;
                q[0] = pin;
            end
            rst_i <= 1'b0;
            chk("pin_in_reset", 32'(rows[i].c.clock_output_fuse), 32'(n > 0));
            chk("pin_oe_n", 32'(!rows[i].c.clock_output_fuse), 32'(oe_n));
            for (k = 0; k < 200 && run !== 1'b1; k++) @(posedge clk_i);
            rng("start_delay", 19 + rows[i].dly, 22 + rows[i].dly, k);
            chk("timer_allowed", 32'(rows[i].alw), 32'(alw));
            if (k == 200) end_sim();
            bus(A_ST, 1'b0, 8'h00, q);
            chk("status", {24'h0, rows[i].alw, 3'h4, rows[i].c.clock_source_select}, q);
            bus(A_PS, 1'b0, 8'h00, q);
            chk("prescale_reset", {30'h0, {2{rows[i].c.divide_by_eight_fuse}}}, q);
            wr(A_TC, 8'h01);
            bus(A_TC, 1'b0, 8'h00, q);
            chk("timer_ctrl", 32'h1, q);
            follow(rows[i].c.clock_source_select, rows[i].alw);
            wake <= 1'b1;
            @(posedge clk_i);
            wake <= 1'b0;
            n = 0;
            for (k = 0; k < 20 + 8 * rows[i].c.divide_by_eight_fuse; k++)
            begin
                @(posedge clk_i);
                if (run === 1'b0) n++;
            end
            rng("wake_wait", 6, 7, n);
            $display("row %0d done", i);
        end
        bus(12'h000, 1'b0, 8'h00, q);
        chk("unmapped", 32'h0, q);
        wr(A_PS, 8'h81);
        wr(A_PS, 8'h02);
        bus(A_PS, 1'b0, 8'h00, q);
        chk("bad_unlock", 32'h0, q);
        wr(A_PS, 8'h80);
        repeat (10) @(posedge clk_i);
        wr(A_PS, 8'h02);
        bus(A_PS, 1'b0, 8'h00, q);
        chk("late_write", 32'h0, q);
        $display("unlock tests done");
        prev = 0;
        for (i = 0; i < 4; i++)
        begin
            wr(A_PS, 8'h80);
            wr(A_PS, {4'h0, codes[i]});
            meas(1 << prev, 1 << codes[i]);
            bus(A_PS, 1'b0, 8'h00, q);
            chk("prescale", {28'h0, codes[i]}, q);
            prev = codes[i];
        end
        $display("divide tests done");
        cfg <= '0;
        bus(A_ST, 1'b0, 8'h00, q);
        chk("static_cfg", 32'hc2, q);
        $display("static test done");
        end_sim();
    end
endmodule
`default_nettype wire
